// ===== dbst_pkg.sv
// constants and types shared by both ends of the command/address link
// assumes one 125 mhz clock common to the controller and the memory model
package dbst_pkg;

	localparam int CLK_PS    = 8000;
	localparam int NUM_BANKS = 8;
	localparam int BANK_W    = 3;
	localparam int TMR_W     = 16;
	// bl8 on a double rate bus keeps the data pins busy four clocks
	localparam int BURST_CYC = 4;

	// times in ns
	localparam int TRP_NS    = 18;
	localparam int ACTIVATE_TO_ACCESS_DELAY_NS   = 18;
	localparam int RFCPB_NS  = 90;
	localparam int RFCAB_NS  = 130;
	localparam int MRR_NS    = 32;
	localparam int MRW_NS    = 80;
	localparam int XP_NS     = 16;
	localparam int INIT_NS   = 200000;

	// least time, rounded up to whole clocks, never below one
	function automatic int dbst_cyc(input int t_ns);
		int c;
		c = (t_ns * 1000 + CLK_PS - 1) / CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam logic [TMR_W-1:0] TRP_CYC   = TMR_W'(dbst_cyc(TRP_NS));
	localparam logic [TMR_W-1:0] ACTIVATE_TO_ACCESS_DELAY_CYC  = TMR_W'(dbst_cyc(ACTIVATE_TO_ACCESS_DELAY_NS));
	localparam logic [TMR_W-1:0] RFCPB_CYC = TMR_W'(dbst_cyc(RFCPB_NS));
	localparam logic [TMR_W-1:0] RFCAB_CYC = TMR_W'(dbst_cyc(RFCAB_NS));
	localparam logic [TMR_W-1:0] MRR_CYC   = TMR_W'(dbst_cyc(MRR_NS));
	localparam logic [TMR_W-1:0] MRW_CYC   = TMR_W'(dbst_cyc(MRW_NS));
	localparam logic [TMR_W-1:0] XP_CYC    = TMR_W'(dbst_cyc(XP_NS));
	localparam logic [TMR_W-1:0] BURST_T   = TMR_W'(BURST_CYC);
	localparam logic [TMR_W-1:0] AP_CYC    =
		TMR_W'(BURST_CYC + dbst_cyc(TRP_NS));
	localparam logic [TMR_W-1:0] TMR_ONE   = TMR_W'(1);

	typedef enum logic [3:0] {
		cmd_nop,
		cmd_act,
		cmd_rd,
		cmd_wr,
		cmd_pre,
		cmd_prea,
		cmd_refpb,
		cmd_refab,
		cmd_mrr,
		cmd_mrw,
		cmd_rst
	} dbst_cmd_e;

	// bk_pwr_on is first so that a cleared register means power-on
	typedef enum logic [3:0] {
		bk_pwr_on,
		bk_idle,
		bk_activating,
		bk_active,
		bk_reading,
		bk_writing,
		bk_rd_ap,
		bk_wr_ap,
		bk_precharging,
		bk_refreshing,
		bk_mr_reading,
		bk_mr_writing,
		bk_resetting
	} dbst_bank_e;

endpackage

// ===== dbst_ca_if.sv
// command/address link between controller and memory bank tracker
// assumes both ends run on the same clock; no clocking block here
`timescale 1ns/1ns
interface dbst_ca_if import dbst_pkg::*; ();

	logic              cke;
	dbst_cmd_e         cmd;
	logic [BANK_W-1:0] bank;
	logic              ap;

	modport ctrl (output cke, output cmd, output bank, output ap);
	modport mem  (input cke, input cmd, input bank, input ap);

endinterface

// ===== dbst_bank_tracker.sv
// memory end: per-bank command state machine of the dram
// assumes the controller drives the link from flops on the same clock
`timescale 1ns/1ns

module dbst_bank_tracker import dbst_pkg::*; #(
	parameter int NB       = NUM_BANKS,
	parameter int INIT_CYC = dbst_cyc(INIT_NS)
) (
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rst,
	input  wire logic           ce,
	// link from the controller
	dbst_ca_if.mem              ca,
	// observed state
	output dbst_bank_e [NB-1:0] bank_state,
	output logic                all_idle,
	output logic                cmd_err
);

	////////////////////////////////////////////////////////////////////////
	if (NB < 1 || NB > (1 << BANK_W))
		$error("bank count does not fit the bank address");
	if (INIT_CYC < 1 || INIT_CYC >= (1 << TMR_W))
		$error("init count does not fit the timer");

	localparam logic [TMR_W-1:0] INIT_T = TMR_W'(INIT_CYC);

	typedef struct packed {
		dbst_bank_e [NB-1:0]             st;
		dbst_bank_e [NB-1:0]             back;
		logic       [NB-1:0][TMR_W-1:0]  tmr;
		logic       [TMR_W-1:0]          init_tmr;
		logic       [TMR_W-1:0]          xp_tmr;
		logic                            cke_prev;
		logic                            err;
	} dbst_dev_s;

	dbst_dev_s  s;
	dbst_dev_s  n;
	logic       live;
	logic       legal;
	logic       idle_all;
	logic       pwr_all;
	logic       pre_all;
	dbst_bank_e cur;

	// state a timed state falls into when its time is met
	function automatic dbst_bank_e dbst_done(input dbst_bank_e st,
		input dbst_bank_e back);
		case (st)
			bk_activating,
			bk_reading,
			bk_writing:     return bk_active;
			bk_mr_reading:  return back;
			bk_rd_ap,
			bk_wr_ap,
			bk_precharging,
			bk_refreshing,
			bk_mr_writing:  return bk_idle;
			default:        return st;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		n          = s;
		n.cke_prev = ca.cke;
		n.err      = 1'b0;
		idle_all   = 1'b1;
		pwr_all    = 1'b1;
		pre_all    = 1'b1;
		legal      = 1'b0;
		cur        = s.st[ca.bank];
		if (ca.cke && !s.cke_prev)
			n.xp_tmr = XP_CYC;
		else if (s.xp_tmr != '0)
			n.xp_tmr = s.xp_tmr - TMR_ONE;
		if (s.init_tmr != '0)
			n.init_tmr = s.init_tmr - TMR_ONE;
		live = ca.cke && s.cke_prev && (s.xp_tmr == '0);
		for (int b = 0; b < NB; b++)
		begin
			idle_all &= (s.st[b] == bk_idle);
			pwr_all  &= (s.st[b] == bk_pwr_on);
			pre_all  &= (s.st[b] == bk_idle) || (s.st[b] == bk_active);
			if (s.tmr[b] != '0)
			begin
				n.tmr[b] = s.tmr[b] - TMR_ONE;
				if (s.tmr[b] == TMR_ONE)
					n.st[b] = dbst_done(s.st[b], s.back[b]);
			end
			// ends in its last init cycle, like the bank timers
			else if (s.st[b] == bk_resetting && s.init_tmr <= TMR_ONE)
				n.st[b] = bk_idle;
		end
		if (live && ca.cmd != cmd_nop)
		begin
			case (ca.cmd)
				cmd_prea:
					if (pre_all)
					begin
						legal = 1'b1;
						for (int b = 0; b < NB; b++)
						begin
							n.st[b]  = bk_precharging;
							n.tmr[b] = TRP_CYC;
						end
					end
				cmd_refab:
					if (idle_all)
					begin
						legal = 1'b1;
						for (int b = 0; b < NB; b++)
						begin
							n.st[b]  = bk_refreshing;
							n.tmr[b] = RFCAB_CYC;
						end
					end
				cmd_mrw:
					if (idle_all)
					begin
						legal = 1'b1;
						for (int b = 0; b < NB; b++)
						begin
							n.st[b]  = bk_mr_writing;
							n.tmr[b] = MRW_CYC;
						end
					end
				cmd_rst:
					if (idle_all || pwr_all)
					begin
						legal      = 1'b1;
						n.init_tmr = INIT_T;
						for (int b = 0; b < NB; b++)
						begin
							n.st[b]  = bk_resetting;
							n.tmr[b] = '0;
						end
					end
				cmd_act:
					if (cur == bk_idle)
					begin
						legal             = 1'b1;
						n.st[ca.bank]  = bk_activating;
						n.tmr[ca.bank] = ACTIVATE_TO_ACCESS_DELAY_CYC;
					end
				// bursts from active, reading or writing
				cmd_rd,
				cmd_wr:
					if (cur == bk_active || cur == bk_reading ||
						cur == bk_writing)
					begin
						legal = 1'b1;
						if (ca.ap)
						begin
							n.st[ca.bank]  = (ca.cmd == cmd_rd) ?
								bk_rd_ap : bk_wr_ap;
							n.tmr[ca.bank] = AP_CYC;
						end
						else
						begin
							n.st[ca.bank]  = (ca.cmd == cmd_rd) ?
								bk_reading : bk_writing;
							n.tmr[ca.bank] = BURST_T;
						end
					end
				// idle bank also waits the precharge period
				cmd_pre:
					if (cur == bk_idle || cur == bk_active)
					begin
						legal          = 1'b1;
						n.st[ca.bank]  = bk_precharging;
						n.tmr[ca.bank] = TRP_CYC;
					end
				cmd_refpb:
					if (cur == bk_idle)
					begin
						legal          = 1'b1;
						n.st[ca.bank]  = bk_refreshing;
						n.tmr[ca.bank] = RFCPB_CYC;
					end
				cmd_mrr:
					if (cur == bk_idle || cur == bk_active ||
						cur == bk_resetting)
					begin
						legal           = 1'b1;
						n.st[ca.bank]   = bk_mr_reading;
						n.back[ca.bank] = cur;
						n.tmr[ca.bank]  = MRR_CYC;
					end
				default:
					legal = 1'b0;
			endcase
		end
		if (ca.cke && s.cke_prev && ca.cmd != cmd_nop && !legal)
			n.err = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s <= '0;
		else if (ce)
			s <= n;
	end

	assign bank_state = s.st;
	assign cmd_err    = s.err;

	always_comb
	begin
		all_idle = 1'b1;
		for (int b = 0; b < NB; b++)
			all_idle &= (s.st[b] == bk_idle);
	end

endmodule

// ===== dbst_ca_ctrl.sv
// controller end: issues user requests on the link only when legal
// assumes the memory end samples the link on the same clock edge
`timescale 1ns/1ns
module dbst_ca_ctrl import dbst_pkg::*; #(
	parameter int NB       = NUM_BANKS,
	parameter int INIT_CYC = dbst_cyc(INIT_NS)
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	// link to the memory
	dbst_ca_if.ctrl                ca,
	// user request
	input  wire logic              req_valid,
	input  wire dbst_cmd_e         req_cmd,
	input  wire logic [BANK_W-1:0] req_bank,
	input  wire logic              req_ap,
	output logic                   req_ready,
	// power-down request, drops cke
	input  wire logic              pd_req
);

	////////////////////////////////////////////////////////////////////////
	if (NB < 1 || NB > (1 << BANK_W))
		$error("bank count does not fit the bank address");
	if (INIT_CYC < 1 || INIT_CYC >= (1 << TMR_W))
		$error("init count does not fit the timer");

	localparam logic [TMR_W-1:0] INIT_T = TMR_W'(INIT_CYC);

	typedef struct packed {
		logic [NB-1:0]            open;
		logic [NB-1:0]            bwr;
		logic [NB-1:0][TMR_W-1:0] btmr;
		logic [NB-1:0][TMR_W-1:0] brt;
		logic [TMR_W-1:0]         dtmr;
		logic [TMR_W-1:0]         xp_tmr;
		logic                     powered;
		logic                     cke;
		dbst_cmd_e                cmd;
		logic [BANK_W-1:0]        bank;
		logic                     ap;
	} dbst_ctl_s;

	dbst_ctl_s s;
	dbst_ctl_s n;
	logic      quiet;
	logic      closed;
	logic      bfree;
	logic      ok;

	////////////////////////////////////////////////////////////////////////
	// timers load at the issue edge, one clock before the memory's,
	// and the next command lands one clock later: both ends agree
	always_comb
	begin
		n       = s;
		n.cmd   = cmd_nop;
		n.ap    = 1'b0;
		n.cke   = ~pd_req;
		quiet   = 1'b1;
		closed  = 1'b1;
		ok      = 1'b0;
		bfree   = (s.btmr[req_bank] == '0) && (s.brt[req_bank] == '0);
		// wait exit time after cke rises
		if (n.cke && !s.cke)
			n.xp_tmr = XP_CYC;
		else if (s.xp_tmr != '0)
			n.xp_tmr = s.xp_tmr - TMR_ONE;
		if (s.dtmr != '0)
			n.dtmr = s.dtmr - TMR_ONE;
		for (int b = 0; b < NB; b++)
		begin
			quiet  &= (s.btmr[b] == '0) && (s.brt[b] == '0);
			closed &= !s.open[b];
			if (s.btmr[b] != '0)
				n.btmr[b] = s.btmr[b] - TMR_ONE;
			if (s.brt[b] != '0)
				n.brt[b] = s.brt[b] - TMR_ONE;
		end
		case (req_cmd)
			cmd_act:   ok = bfree && !s.open[req_bank];
			// write waits for read burst end
			// read waits for write burst end
			cmd_rd:    ok = (s.btmr[req_bank] == '0) && s.open[req_bank] &&
				((s.brt[req_bank] == '0) || !s.bwr[req_bank]);
			cmd_wr:    ok = (s.btmr[req_bank] == '0) && s.open[req_bank] &&
				((s.brt[req_bank] == '0) || s.bwr[req_bank]);
			// idle bank may be precharged too
			cmd_pre:   ok = bfree;
			// every bank in a valid state
			cmd_prea:  ok = quiet;
			// per-bank refresh only to idle bank
			cmd_refpb: ok = bfree && !s.open[req_bank];
			cmd_refab,
			cmd_mrw,
			cmd_rst:   ok = quiet && closed;
			cmd_mrr:   ok = bfree;
			default:   ok = 1'b0;
		endcase
		if (!s.powered && req_cmd != cmd_rst)
			ok = 1'b0;
		req_ready = ok && s.cke && n.cke && (s.xp_tmr == '0) &&
			(s.dtmr == '0);
		if (req_valid && req_ready)
		begin
			n.cmd  = req_cmd;
			n.bank = req_bank;
			n.ap   = req_ap && (req_cmd == cmd_rd || req_cmd == cmd_wr);
			case (req_cmd)
				cmd_act:
				begin
					n.open[req_bank] = 1'b1;
					n.btmr[req_bank] = ACTIVATE_TO_ACCESS_DELAY_CYC;
				end
				cmd_rd,
				cmd_wr:
				begin
					n.bwr[req_bank] = (req_cmd == cmd_wr);
					n.brt[req_bank] = BURST_T;
					if (req_ap)
					begin
						n.open[req_bank] = 1'b0;
						n.btmr[req_bank] = AP_CYC;
					end
				end
				cmd_pre:
				begin
					n.open[req_bank] = 1'b0;
					n.btmr[req_bank] = TRP_CYC;
				end
				cmd_prea:
					for (int b = 0; b < NB; b++)
					begin
						n.open[b] = 1'b0;
						n.btmr[b] = TRP_CYC;
					end
				cmd_refpb: n.dtmr = RFCPB_CYC;
				cmd_refab: n.dtmr = RFCAB_CYC;
				cmd_mrw:   n.dtmr = MRW_CYC;
				cmd_mrr:   n.dtmr = MRR_CYC;
				cmd_rst:
				begin
					n.dtmr    = INIT_T;
					n.powered = 1'b1;
				end
				default:   n.cmd = cmd_nop;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s <= '0;
		else if (ce)
			s <= n;
	end

	assign ca.cke  = s.cke;
	assign ca.cmd  = s.cmd;
	assign ca.bank = s.bank;
	assign ca.ap   = s.ap;

endmodule

// ===== dbst_link_assertions.sv
// assertions on the command link and the memory end's state outputs
// assumes one clock, instantiated beside the link joining both ends
`timescale 1ns/1ns
module dbst_link_assertions import dbst_pkg::*; #(
	parameter int NB = NUM_BANKS
) (
	// clock and reset
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              ce,
	// link
	input wire logic              cke,
	input wire dbst_cmd_e         cmd,
	input wire logic [BANK_W-1:0] bank,
	// memory end
	input dbst_bank_e [NB-1:0]    bank_state,
	input wire logic              all_idle
);

	default clocking dc @(posedge clk); endclocking
	// a held clock enable stretches every timed state
	default disable iff (rst || !ce);

	logic every_idle;
	logic any_hush;

	always_comb
	begin
		every_idle = 1'b1;
		any_hush   = 1'b0;
		for (int i = 0; i < NB; i++)
		begin
			every_idle &= (bank_state[i] == bk_idle);
			any_hush   |= bank_state[i] inside {bk_mr_writing,
				bk_mr_reading, bk_refreshing};
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_idle_flag_match: assert property (all_idle == every_idle)
		else $error("idle flag disagrees with bank states");
	a_act_opens_row: assert property (cmd == cmd_act
		|=> bank_state[$past(bank)] == bk_activating)
		else $error("activate did not start row activation");
	a_nop_when_off: assert property (!cke |-> cmd == cmd_nop)
		else $error("command sent with clock enable low");
	// mode reads left out: they are allowed while the device resets
	a_busy_bank_quiet: assert property (cmd inside {cmd_act, cmd_rd,
		cmd_wr, cmd_pre, cmd_refpb} |-> !(bank_state[bank] inside
		{bk_activating, bk_precharging, bk_rd_ap, bk_wr_ap}))
		else $error("command sent to a bank in a timed state");
	a_busy_all_quiet: assert property (any_hush |-> cmd == cmd_nop)
		else $error("command sent during refresh or register access");
	a_global_needs_idle: assert property (
		cmd inside {cmd_refab, cmd_mrw} |-> all_idle)
		else $error("device-wide command while not all idle");
	a_refpb_from_idle: assert property (
		cmd == cmd_refpb |-> bank_state[bank] == bk_idle)
		else $error("bank refresh to a bank that is not idle");
	a_refab_length: assert property (cmd == cmd_refab
		|=> (bank_state[0] == bk_refreshing)[*8] ##9
		bank_state[0] == bk_refreshing ##1 bank_state[0] == bk_idle)
		else $error("all-bank refresh length wrong");

	for (genvar g = 0; g < NB; g++)
	begin : per_bank
		a_activate_len: assert property ($changed(bank_state[g]) &&
			bank_state[g] == bk_activating |->
			(bank_state[g] == bk_activating)[*3] ##1
			bank_state[g] == bk_active)
			else $error("row activation length wrong");
		a_precharge_len: assert property ($changed(bank_state[g]) &&
			bank_state[g] == bk_precharging |->
			(bank_state[g] == bk_precharging)[*3] ##1
			bank_state[g] == bk_idle)
			else $error("precharge length wrong");
		a_ap_burst_len: assert property ($changed(bank_state[g]) &&
			bank_state[g] inside {bk_rd_ap, bk_wr_ap} |->
			(bank_state[g] inside {bk_rd_ap, bk_wr_ap})[*7] ##1
			bank_state[g] == bk_idle)
			else $error("auto-precharge burst length wrong");
	end

	c_refab: cover property (cmd == cmd_refab);
	c_mrr: cover property (cmd == cmd_mrr);
	c_prea: cover property (cmd == cmd_prea);

endmodule

// ===== dram_bank_state_tracker_bench.sv
// self-checking bench: controller and memory end joined by the link
// a second memory end is driven directly to send illegal commands
`timescale 1ns/1ns
module dram_bank_state_tracker_bench import dbst_pkg::*;;

	localparam int INIT_T = 20;

	logic                       clk       = 1'b0;
	logic                       rst       = 1'b1;
	logic                       ce        = 1'b1;
	logic                       pd_req    = 1'b0;
	logic                       req_valid = 1'b0;
	dbst_cmd_e                  req_cmd   = cmd_nop;
	logic [BANK_W-1:0]          req_bank  = 3'h0;
	logic                       req_ap    = 1'b0;
	logic                       req_ready;
	dbst_bank_e [NUM_BANKS-1:0] bank_state;
	dbst_bank_e [NUM_BANKS-1:0] err_state;
	logic                       all_idle;
	logic                       err_idle;
	logic                       cmd_err;
	logic                       good_err;
	int                         fail_count = 0;
	int                         n_compared = 0;

	always #4 clk = ~clk;

	dbst_ca_if ca ();
	dbst_ca_if ca_bad ();

	dbst_ca_ctrl #(.INIT_CYC(INIT_T)) dbst_ca_ctrl_i (.clk(clk), .rst(rst),
		.ce(ce), .ca(ca.ctrl), .req_valid(req_valid), .req_cmd(req_cmd),
		.req_bank(req_bank), .req_ap(req_ap), .req_ready(req_ready),
		.pd_req(pd_req));
	dbst_bank_tracker #(.INIT_CYC(INIT_T)) dbst_bank_tracker_i (.clk(clk),
		.rst(rst), .ce(ce), .ca(ca.mem), .bank_state(bank_state),
		.all_idle(all_idle), .cmd_err(good_err));
	dbst_bank_tracker #(.INIT_CYC(INIT_T)) dbst_bank_tracker_i_bad (
		.clk(clk), .rst(rst), .ce(ce), .ca(ca_bad.mem),
		.bank_state(err_state), .all_idle(err_idle), .cmd_err(cmd_err));
	dbst_link_assertions #(.NB(NUM_BANKS)) dbst_link_assertions_i (
		.clk(clk), .rst(rst), .ce(ce), .cke(ca.cke), .cmd(ca.cmd),
		.bank(ca.bank), .bank_state(bank_state), .all_idle(all_idle));

	////////////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask

	task close_out();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// entered at a falling edge; link must show the command one cycle
	task req(input dbst_cmd_e c, input logic [BANK_W-1:0] b, input logic a);
		req_cmd   = c;
		req_bank  = b;
		req_ap    = a;
		req_valid = 1'b1;
		#1;
		repeat (200)
			if (req_ready !== 1'b1)
			begin
				@(negedge clk);
				#1;
			end
		@(negedge clk);
		req_valid = 1'b0;
		chk(ca.cmd, c);
		chk(ca.bank, b);
		@(negedge clk);
		chk(ca.cmd, cmd_nop);
		chk(good_err, 1'b0);
	endtask

	task dwell(input int b, input dbst_bank_e s, input int exp);
		int n;
		n = 0;
		repeat (64) if (bank_state[b] !== s) @(negedge clk);
		while (bank_state[b] === s && n < 64)
		begin
			n++;
			@(negedge clk);
		end
		chk(TMR_W'(n), TMR_W'(exp));
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_reset();
		chk(bank_state[0], bk_pwr_on);
		chk(all_idle, 1'b0);
		req(cmd_rst, 3'h0, 1'b0);
		chk(bank_state[7], bk_resetting);
		repeat (INIT_T + 40) if (all_idle !== 1'b1) @(negedge clk);
		chk(all_idle, 1'b1);
		$display("test reset done");
	endtask

	task t_burst();
		req(cmd_act, 3'h2, 1'b0);
		dwell(2, bk_activating, ACTIVATE_TO_ACCESS_DELAY_CYC);
		req(cmd_rd, 3'h2, 1'b0);
		chk(bank_state[2], bk_reading);
		req(cmd_rd, 3'h2, 1'b1);
		dwell(2, bk_rd_ap, AP_CYC);
		chk(bank_state[2], bk_idle);
		req(cmd_act, 3'h5, 1'b0);
		req(cmd_wr, 3'h5, 1'b0);
		chk(bank_state[5], bk_writing);
		req(cmd_wr, 3'h5, 1'b1);
		dwell(5, bk_wr_ap, AP_CYC);
		chk(bank_state[5], bk_idle);
		$display("test burst done");
	endtask

	task t_pre();
		req(cmd_act, 3'h4, 1'b0);
		dwell(4, bk_activating, ACTIVATE_TO_ACCESS_DELAY_CYC);
		chk(bank_state[4], bk_active);
		req(cmd_pre, 3'h4, 1'b0);
		dwell(4, bk_precharging, TRP_CYC);
		req(cmd_pre, 3'h1, 1'b0);
		dwell(1, bk_precharging, TRP_CYC);
		req(cmd_act, 3'h3, 1'b0);
		req(cmd_prea, 3'h0, 1'b0);
		dwell(3, bk_precharging, TRP_CYC);
		chk(all_idle, 1'b1);
		$display("test precharge done");
	endtask

	task t_refresh();
		req(cmd_refpb, 3'h4, 1'b0);
		dwell(4, bk_refreshing, RFCPB_CYC);
		req(cmd_refab, 3'h0, 1'b0);
		dwell(0, bk_refreshing, RFCAB_CYC);
		chk(all_idle, 1'b1);
		$display("test refresh done");
	endtask

	task t_mode();
		req(cmd_mrw, 3'h0, 1'b0);
		dwell(6, bk_mr_writing, MRW_CYC);
		req(cmd_act, 3'h6, 1'b0);
		dwell(6, bk_activating, ACTIVATE_TO_ACCESS_DELAY_CYC);
		req(cmd_mrr, 3'h6, 1'b0);
		dwell(6, bk_mr_reading, MRR_CYC);
		chk(bank_state[6], bk_active);
		$display("test mode register done");
	endtask

	// power-down exit, then a held clock enable on the good pair
	task t_power();
		int n;
		n        = 0;
		req_cmd  = cmd_act;
		req_bank = 3'h1;
		pd_req   = 1'b1;
		repeat (3) @(negedge clk);
		chk(ca.cke, 1'b0);
		chk(req_ready, 1'b0);
		pd_req = 1'b0;
		while (req_ready !== 1'b1 && n < 16)
		begin
			@(negedge clk);
			n++;
		end
		// one clock for cke to rise, then the exit time
		chk(TMR_W'(n), XP_CYC + TMR_ONE);
		req(cmd_act, 3'h1, 1'b0);
		chk(bank_state[1], bk_activating);
		ce = 1'b0;
		repeat (4) @(negedge clk);
		chk(bank_state[1], bk_activating);
		ce = 1'b1;
		dwell(1, bk_activating, ACTIVATE_TO_ACCESS_DELAY_CYC);
		$display("test power and hold done");
	endtask

	// second memory end, link driven here with rule-breaking commands
	task t_refused();
		ca_bad.cke = 1'b1;
		repeat (4) @(negedge clk);
		ca_bad.cmd = cmd_rst;
		@(negedge clk);
		ca_bad.cmd = cmd_nop;
		repeat (INIT_T + 40) if (err_idle !== 1'b1) @(negedge clk);
		ca_bad.cmd = cmd_rd;
		@(negedge clk);
		ca_bad.cmd = cmd_nop;
		chk(cmd_err, 1'b1);
		@(negedge clk);
		chk(cmd_err, 1'b0);
		chk(err_state[0], bk_idle);
		ca_bad.cke = 1'b0;
		ca_bad.cmd = cmd_act;
		repeat (2) @(negedge clk);
		ca_bad.cmd = cmd_nop;
		chk(err_state[0], bk_idle);
		chk(cmd_err, 1'b0);
		$display("test refused done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		ca_bad.cke  = 1'b0;
		ca_bad.cmd  = cmd_nop;
		ca_bad.bank = 3'h0;
		ca_bad.ap   = 1'b0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_burst();
		t_pre();
		t_refresh();
		t_mode();
		t_power();
		t_refused();
		close_out();
	end

	// the tests need well under a thousand cycles
	initial
	begin
		#40000;
		fail_count++;
		close_out();
	end

endmodule
